/* common/lin_serial_pkg.sv */
// Constants for the LIN serial status and first control register block.
// Assumes a 100 MHz register clock and an AXI4-Lite master with 32-bit data.
package lin_serial_pkg;
  localparam int CLK_HZ = 100_000_000;
  localparam int BAUD_RATE = 19200;
  localparam int OVERSAMPLE = 16;
  localparam int TICK_CYCLES = CLK_HZ / (BAUD_RATE * OVERSAMPLE);

  // Register byte offsets
  localparam logic [7:0] OFS_STATUS = 8'h00;
  localparam logic [7:0] OFS_DATA = 8'h04;
  localparam logic [7:0] OFS_CONTROL_ONE = 8'h08;
  localparam logic [7:0] OFS_LIN_CONFIG = 8'h0C;
  localparam logic [7:0] OFS_IRQ_STATUS = 8'h10;
  localparam logic [7:0] OFS_IRQ_MASK = 8'h14;

  // Status register bits
  localparam int ST_PARITY = 0;
  localparam int ST_FRAMING = 1;
  localparam int ST_NOISE = 2;
  localparam int ST_HEADER = 3;
  localparam int ST_TX_BUSY = 4;
  localparam int ST_RX_READY = 5;

  // Control register one bits
  localparam int C1_RX_NINTH = 7;
  localparam int C1_TX_NINTH = 6;
  localparam int C1_POWER_DOWN = 5;
  localparam int C1_WORD_LEN = 4;
  localparam int C1_WAKE = 3;
  localparam int C1_PARITY_CHECK = 2;
  localparam int C1_RESERVED = 1;
  localparam int C1_PARITY_IRQ = 0;
  localparam logic [7:0] C1_RESET = 8'h00;

  // LIN configuration bits
  localparam int LC_LIN_ENABLE = 0;
  localparam int LC_SLAVE = 1;
  localparam int LC_HEADER_METHOD = 2;
  localparam int LC_LIN_PARITY = 3;
  localparam logic [3:0] LC_RESET = 4'h0;

  // Interrupt event bits
  localparam int EV_RX_DONE = 0;
  localparam int EV_FRAMING = 1;
  localparam int EV_PARITY = 2;
  localparam int EV_BREAK = 3;
  localparam logic [3:0] IRQ_RESET = 4'h0;

  // Receive sample points within a bit, data bit counts and header countdown values
  localparam logic [3:0] SAMPLE_FIRST = 4'h7;
  localparam logic [3:0] SAMPLE_LAST = 4'h9;
  localparam logic [3:0] BIT_END = 4'hF;
  localparam logic [3:0] DATA_BITS_8 = 4'h8;
  localparam logic [3:0] DATA_BITS_9 = 4'h9;
  localparam logic [1:0] HDR_EXPECT_SYNC = 2'h2;
  localparam logic [1:0] HDR_EXPECT_ID = 2'h1;

  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [0:0] {LINE_IDLE = 1'b0, LINE_FRAME = 1'b1} line_state_t;
endpackage

/* rtl/lin_serial_status_control.sv */
// UART core with LIN status flags, first control register and AXI4-Lite slave.
// Assumes rxd is asynchronous to ref_clk; all other inputs are on ref_clk.
`timescale 1ns/1ns
module lin_serial_status_control #(
  parameter int ADDR_WIDTH = 8,
  parameter logic [8:0] TICK_DIV = 9'(lin_serial_pkg::TICK_CYCLES)
)(
  input wire logic ref_clk,
  input wire logic resetn,
  input wire logic [ADDR_WIDTH-1:0] awaddr,
  input wire logic [2:0] awprot,
  input wire logic awvalid,
  output logic awready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  input wire logic [ADDR_WIDTH-1:0] araddr,
  input wire logic [2:0] arprot,
  input wire logic arvalid,
  output logic arready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  input wire logic rxd,
  output logic txd,
  output logic irq,
  output logic wakeAddressMark
);
  typedef struct packed {
    logic syncA;
    logic syncB;
    logic [8:0] tickCnt;
    lin_serial_pkg::line_state_t rxState;
    logic [3:0] rxOs;
    logic [3:0] rxIdx;
    logic [2:0] rxSamp;
    logic [8:0] rxShift;
    logic rxNoise;
    logic rxOnes;
    lin_serial_pkg::line_state_t txState;
    logic [3:0] txOs;
    logic [3:0] txIdx;
    logic [10:0] txShift;
    logic txd;
    logic [7:0] ctrl;
    logic [3:0] cfg;
    logic nf;
    logic fe;
    logic pe;
    logic hdf;
    logic [7:0] rxData;
    logic rxReady;
    logic armed;
    logic [1:0] hdrCnt;
    logic [3:0] irqStat;
    logic [3:0] irqMask;
    logic irq;
    logic wake;
    logic awready;
    logic wready;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [1:0] rresp;
    logic [31:0] rdata;
  } state_t;

  state_t s;
  state_t next_s;
  logic tick;
  logic stopped;
  logic lin;
  logic slave;
  logic vote;
  logic brk;
  logic [3:0] nb;
  logic [8:0] word;
  logic [7:0] dat;
  logic parErr;
  logic wrTake;
  logic rdTake;
  logic [7:0] wa;
  logic [7:0] ra;

  always_comb
  begin
    next_s = s;
    tick = 1'b0;
    vote = 1'b0;
    brk = 1'b0;
    parErr = 1'b0;
    word = 9'h000;
    dat = 8'h00;
    lin = s.cfg[lin_serial_pkg::LC_LIN_ENABLE];
    slave = s.cfg[lin_serial_pkg::LC_SLAVE];
    // Word length fixes the data bit count; software keeps it steady
    nb = s.ctrl[lin_serial_pkg::C1_WORD_LEN] ? lin_serial_pkg::DATA_BITS_9
                                           : lin_serial_pkg::DATA_BITS_8;
    // Stop only between frames so a running byte always completes
    stopped = s.ctrl[lin_serial_pkg::C1_POWER_DOWN] && s.rxState == lin_serial_pkg::LINE_IDLE
              && s.txState == lin_serial_pkg::LINE_IDLE;
    wa = 8'(awaddr);
    ra = 8'(araddr);
    wrTake = s.awready && awvalid && s.wready && wvalid;
    rdTake = s.arready && arvalid;
    next_s.syncA = rxd;
    next_s.syncB = s.syncA;

    if (stopped)
    begin
      next_s.tickCnt = 9'h000;
    end
    else if (s.tickCnt == TICK_DIV - 9'h001)
    begin
      next_s.tickCnt = 9'h000;
      tick = 1'b1;
    end
    else
    begin
      next_s.tickCnt = s.tickCnt + 9'h001;
    end

    // Bus write: address and data are taken in the same cycle
    next_s.awready = awvalid && wvalid && !s.awready && !s.bvalid;
    next_s.wready = awvalid && wvalid && !s.awready && !s.bvalid;
    if (s.bvalid && bready)
    begin
      next_s.bvalid = 1'b0;
    end
    if (wrTake)
    begin
      next_s.bvalid = 1'b1;
      next_s.bresp = lin_serial_pkg::RESP_OKAY;
      if (wa == lin_serial_pkg::OFS_STATUS)
      begin
        next_s.bresp = lin_serial_pkg::RESP_OKAY;
      end
      else if (wa == lin_serial_pkg::OFS_DATA)
      begin
        if (s.armed)
        begin
          next_s.pe = 1'b0;
          next_s.armed = 1'b0;
        end
        if (wstrb[0] && s.txState == lin_serial_pkg::LINE_IDLE
            && !s.ctrl[lin_serial_pkg::C1_POWER_DOWN])
        begin
          next_s.txState = lin_serial_pkg::LINE_FRAME;
          next_s.txOs = 4'h0;
          next_s.txIdx = 4'h0;
          next_s.txShift = {1'b1, s.ctrl[lin_serial_pkg::C1_WORD_LEN]
                            ? s.ctrl[lin_serial_pkg::C1_TX_NINTH] : 1'b1,
                            wdata[7:0], 1'b0};
        end
      end
      else if (wa == lin_serial_pkg::OFS_CONTROL_ONE)
      begin
        if (wstrb[0])
        begin
          next_s.ctrl[6:2] = wdata[6:2];
          next_s.ctrl[lin_serial_pkg::C1_RESERVED] = 1'b0;
          next_s.ctrl[lin_serial_pkg::C1_PARITY_IRQ] = wdata[0];
        end
      end
      else if (wa == lin_serial_pkg::OFS_LIN_CONFIG)
      begin
        if (wstrb[0])
        begin
          next_s.cfg = wdata[3:0];
        end
      end
      else if (wa == lin_serial_pkg::OFS_IRQ_STATUS)
      begin
        if (wstrb[0])
        begin
          next_s.irqStat = s.irqStat & ~wdata[3:0];
        end
      end
      else if (wa == lin_serial_pkg::OFS_IRQ_MASK)
      begin
        if (wstrb[0])
        begin
          next_s.irqMask = wdata[3:0];
        end
      end
      else
      begin
        next_s.bresp = lin_serial_pkg::RESP_SLVERR;
      end
    end

    // Bus read
    next_s.arready = arvalid && !s.arready && !s.rvalid;
    if (s.rvalid && rready)
    begin
      next_s.rvalid = 1'b0;
    end
    if (rdTake)
    begin
      next_s.rvalid = 1'b1;
      next_s.rresp = lin_serial_pkg::RESP_OKAY;
      next_s.rdata = 32'h0000_0000;
      if (ra == lin_serial_pkg::OFS_STATUS)
      begin
        next_s.rdata[lin_serial_pkg::ST_PARITY] = s.pe;
        next_s.rdata[lin_serial_pkg::ST_FRAMING] = s.fe;
        next_s.rdata[lin_serial_pkg::ST_NOISE] = s.nf;
        next_s.rdata[lin_serial_pkg::ST_HEADER] = s.hdf;
        next_s.rdata[lin_serial_pkg::ST_TX_BUSY] = s.txState == lin_serial_pkg::LINE_FRAME;
        next_s.rdata[lin_serial_pkg::ST_RX_READY] = s.rxReady;
        next_s.armed = 1'b1;
      end
      else if (ra == lin_serial_pkg::OFS_DATA)
      begin
        next_s.rdata[7:0] = s.rxData;
        if (s.armed)
        begin
          next_s.fe = 1'b0;
          next_s.pe = 1'b0;
          next_s.nf = 1'b0;
          next_s.hdf = 1'b0;
          next_s.rxReady = 1'b0;
          next_s.armed = 1'b0;
        end
      end
      else if (ra == lin_serial_pkg::OFS_CONTROL_ONE)
      begin
        next_s.rdata[7:0] = s.ctrl;
      end
      else if (ra == lin_serial_pkg::OFS_LIN_CONFIG)
      begin
        next_s.rdata[3:0] = s.cfg;
      end
      else if (ra == lin_serial_pkg::OFS_IRQ_STATUS)
      begin
        next_s.rdata[3:0] = s.irqStat;
      end
      else if (ra == lin_serial_pkg::OFS_IRQ_MASK)
      begin
        next_s.rdata[3:0] = s.irqMask;
      end
      else
      begin
        next_s.rresp = lin_serial_pkg::RESP_SLVERR;
      end
    end

    // Transmitter, LSB first, sixteen ticks per bit
    if (s.txState == lin_serial_pkg::LINE_FRAME && tick)
    begin
      next_s.txOs = s.txOs + 4'h1;
      if (s.txOs == lin_serial_pkg::BIT_END)
      begin
        next_s.txShift = {1'b1, s.txShift[10:1]};
        next_s.txIdx = s.txIdx + 4'h1;
        if (s.txIdx == nb + 4'h1)
        begin
          next_s.txState = lin_serial_pkg::LINE_IDLE;
        end
      end
    end
    next_s.txd = next_s.txState == lin_serial_pkg::LINE_FRAME ? next_s.txShift[0] : 1'b1;

    // Receiver; sets come after bus clears so an event in the clear cycle wins
    if (s.rxState == lin_serial_pkg::LINE_IDLE)
    begin
      if (tick && !s.syncB)
      begin
        next_s.rxState = lin_serial_pkg::LINE_FRAME;
        next_s.rxOs = 4'h0;
        next_s.rxIdx = 4'h0;
        next_s.rxNoise = 1'b0;
        next_s.rxOnes = 1'b0;
      end
    end
    else if (tick)
    begin
      next_s.rxOs = s.rxOs + 4'h1;
      if (s.rxOs >= lin_serial_pkg::SAMPLE_FIRST && s.rxOs <= lin_serial_pkg::SAMPLE_LAST)
      begin
        next_s.rxSamp = {s.rxSamp[1:0], s.syncB};
      end
      if (s.rxOs == lin_serial_pkg::BIT_END)
      begin
        vote = (s.rxSamp[0] & s.rxSamp[1]) | (s.rxSamp[0] & s.rxSamp[2])
               | (s.rxSamp[1] & s.rxSamp[2]);
        if (s.rxSamp != 3'b000 && s.rxSamp != 3'b111)
        begin
          next_s.rxNoise = 1'b1;
        end
        next_s.rxIdx = s.rxIdx + 4'h1;
        if (s.rxIdx == 4'h0 && vote)
        begin
          next_s.rxState = lin_serial_pkg::LINE_IDLE;
        end
        else if (s.rxIdx != 4'h0 && s.rxIdx <= nb)
        begin
          next_s.rxShift = {vote, s.rxShift[8:1]};
          next_s.rxOnes = s.rxOnes | vote;
        end
        else if (s.rxIdx == nb + 4'h1)
        begin
          next_s.rxState = lin_serial_pkg::LINE_IDLE;
          brk = !vote && !s.rxOnes;
          if (!vote && !(lin && slave && brk))
          begin
            next_s.fe = 1'b1;
            next_s.irqStat[lin_serial_pkg::EV_FRAMING] = 1'b1;
          end
          if (next_s.rxNoise && !(lin && slave))
          begin
            next_s.nf = 1'b1;
          end
          if (brk)
          begin
            if (lin && slave && !s.cfg[lin_serial_pkg::LC_HEADER_METHOD])
            begin
              next_s.hdf = 1'b1;
            end
            if (lin)
            begin
              next_s.hdrCnt = lin_serial_pkg::HDR_EXPECT_SYNC;
            end
            next_s.irqStat[lin_serial_pkg::EV_BREAK] = 1'b1;
          end
          else
          begin
            word = s.ctrl[lin_serial_pkg::C1_WORD_LEN] ? s.rxShift : {1'b0, s.rxShift[8:1]};
            dat = word[7:0];
            if (s.cfg[lin_serial_pkg::LC_LIN_PARITY])
            begin
              // Identifier byte: bit 6 and bit 7 protect the six id bits
              parErr = s.hdrCnt == lin_serial_pkg::HDR_EXPECT_ID
                       && (dat[6] != (dat[0] ^ dat[1] ^ dat[2] ^ dat[4])
                       || dat[7] != !(dat[1] ^ dat[3] ^ dat[4] ^ dat[5]));
            end
            else
            begin
              parErr = ^word;
            end
            if (parErr && s.ctrl[lin_serial_pkg::C1_PARITY_CHECK])
            begin
              next_s.pe = 1'b1;
              next_s.irqStat[lin_serial_pkg::EV_PARITY] = 1'b1;
            end
            if (s.hdrCnt != 2'h0)
            begin
              next_s.hdrCnt = s.hdrCnt - 2'h1;
            end
            next_s.rxData = dat;
            next_s.ctrl[lin_serial_pkg::C1_RX_NINTH] =
              s.ctrl[lin_serial_pkg::C1_WORD_LEN] ? s.rxShift[8]
                                                  : s.ctrl[lin_serial_pkg::C1_RX_NINTH];
            next_s.rxReady = 1'b1;
            next_s.irqStat[lin_serial_pkg::EV_RX_DONE] = 1'b1;
          end
        end
      end
    end

    next_s.wake = next_s.cfg[lin_serial_pkg::LC_LIN_ENABLE]
                  | next_s.ctrl[lin_serial_pkg::C1_WAKE];
    next_s.irq = (|(next_s.irqStat & next_s.irqMask))
                 | (next_s.pe & next_s.ctrl[lin_serial_pkg::C1_PARITY_IRQ]);
  end

  always_ff @(posedge ref_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      s <= '0;
      s.syncA <= 1'b1;
      s.syncB <= 1'b1;
      s.txd <= 1'b1;
      s.ctrl <= lin_serial_pkg::C1_RESET;
      s.cfg <= lin_serial_pkg::LC_RESET;
      s.irqStat <= lin_serial_pkg::IRQ_RESET;
      s.irqMask <= lin_serial_pkg::IRQ_RESET;
    end
    else
    begin
      s <= next_s;
    end
  end

  assign awready = s.awready;
  assign wready = s.wready;
  assign bvalid = s.bvalid;
  assign bresp = s.bresp;
  assign arready = s.arready;
  assign rvalid = s.rvalid;
  assign rresp = s.rresp;
  assign rdata = s.rdata;
  assign txd = s.txd;
  assign irq = s.irq;
  assign wakeAddressMark = s.wake;

  chk_noise_slave: assert property (@(posedge ref_clk) disable iff (!resetn)
    $rose(s.nf) |-> $past(!(s.cfg[lin_serial_pkg::LC_LIN_ENABLE] && s.cfg[lin_serial_pkg::LC_SLAVE])))
    else $error("noise flag set in LIN slave role");
  chk_slave_framing: assert property (@(posedge ref_clk) disable iff (!resetn)
    $rose(s.fe) && $past(s.cfg[lin_serial_pkg::LC_LIN_ENABLE] && s.cfg[lin_serial_pkg::LC_SLAVE])
    |-> $past(s.rxOnes))
    else $error("slave framing error without a recessive bit");
  chk_break_header: assert property (@(posedge ref_clk) disable iff (!resetn)
    $rose(s.hdf) |-> !$rose(s.fe))
    else $error("break raised framing error in slave role");
  chk_framing_clear: assert property (@(posedge ref_clk) disable iff (!resetn)
    $fell(s.fe) |-> $past(s.armed && rdTake && ra == lin_serial_pkg::OFS_DATA))
    else $error("framing flag cleared outside the read sequence");
  chk_parity_clear: assert property (@(posedge ref_clk) disable iff (!resetn)
    $fell(s.pe) |-> $past(s.armed && ((rdTake && ra == lin_serial_pkg::OFS_DATA)
                                      || (wrTake && wa == lin_serial_pkg::OFS_DATA))))
    else $error("parity flag cleared outside the access sequence");
  chk_parity_enable: assert property (@(posedge ref_clk) disable iff (!resetn)
    $rose(s.pe) |-> $past(s.ctrl[lin_serial_pkg::C1_PARITY_CHECK]))
    else $error("parity flag set with checking off");
  chk_parity_irq: assert property (@(posedge ref_clk) disable iff (!resetn)
    s.pe && s.ctrl[lin_serial_pkg::C1_PARITY_IRQ] |-> irq)
    else $error("parity interrupt missing");
  chk_wake_lin: assert property (@(posedge ref_clk) disable iff (!resetn)
    s.cfg[lin_serial_pkg::LC_LIN_ENABLE] |-> wakeAddressMark)
    else $error("wake method not replaced by LIN enable");
  chk_powerdown_idle: assert property (@(posedge ref_clk) disable iff (!resetn)
    stopped |=> txd && s.tickCnt == 9'h000)
    else $error("prescaler or output running while powered down");
endmodule

/* verif/lin_node_model.sv */
// Far-side LIN node: sends frames on rxd and captures frames from txd.
// Assumes the bench runs the design with a 32-clock bit time on ref_clk.
`timescale 1ns/1ns
module lin_node_model #(
  parameter int BIT_CYCLES = 32
)(
  input wire logic ref_clk,
  input wire logic txd,
  output logic rxd
);
  initial
  begin
    rxd = 1'b1;
  end

  // Line is recessive high between frames, as the pull-up leaves it
  task automatic send_frame(input logic [8:0] bits, input int nBits, input logic stopBit,
                            input logic glitch);
    logic val;
    for (int k = 0; k <= nBits + 1; k++)
    begin
      val = (k == 0) ? 1'b0 : ((k <= nBits) ? bits[k-1] : stopBit);
      rxd <= val;
      if (glitch && k == 3)
      begin
        // Short spike meant to upset one of the three centre samples only
        repeat (18) @(posedge ref_clk);
        rxd <= ~val;
        repeat (2) @(posedge ref_clk);
        rxd <= val;
        repeat (BIT_CYCLES - 20) @(posedge ref_clk);
      end
      else
      begin
        repeat (BIT_CYCLES) @(posedge ref_clk);
      end
    end
    rxd <= 1'b1;
    repeat (40) @(posedge ref_clk);
  endtask

  task automatic capture(input int nBits, output logic [8:0] bits, output logic stopBit);
    int n;
    bits = 9'h000;
    n = 0;
    while (txd !== 1'b0 && n < 2000)
    begin
      @(posedge ref_clk);
      n++;
    end
    repeat (BIT_CYCLES / 2) @(posedge ref_clk);
    for (int k = 0; k < nBits; k++)
    begin
      repeat (BIT_CYCLES) @(posedge ref_clk);
      bits[k] = txd;
    end
    repeat (BIT_CYCLES) @(posedge ref_clk);
    stopBit = txd;
    repeat (BIT_CYCLES / 2 + 4) @(posedge ref_clk);
  endtask

  task automatic quiet(input int cycles, output logic ok);
    ok = 1'b1;
    repeat (cycles)
    begin
      @(posedge ref_clk);
      if (txd !== 1'b1)
        ok = 1'b0;
    end
  endtask
endmodule

/* verif/test_lin_serial_status_control.sv */
// Bench for the LIN status and first control register block: AXI4-Lite master
// tasks, a receive table, then hand tests. Design runs with TICK_DIV of 2.
`timescale 1ns/1ns
module test_lin_serial_status_control;
  typedef struct {
    logic [7:0] ctrl;
    logic [3:0] lin;
    logic [8:0] bits;
    int nBits;
    logic stopBit;
    logic glitch;
    logic [3:0] flags;
    logic [7:0] data;
  } rx_row_t;
  localparam logic [7:0] ST = lin_serial_pkg::OFS_STATUS;
  localparam logic [7:0] DT = lin_serial_pkg::OFS_DATA;
  localparam logic [7:0] C1 = lin_serial_pkg::OFS_CONTROL_ONE;
  localparam logic [7:0] LC = lin_serial_pkg::OFS_LIN_CONFIG;
  localparam logic [7:0] IS = lin_serial_pkg::OFS_IRQ_STATUS;
  localparam logic [7:0] IM = lin_serial_pkg::OFS_IRQ_MASK;
  logic ref_clk;
  logic resetn = 1'b0;
  logic [7:0] awaddr = 8'h00;
  logic [7:0] araddr = 8'h00;
  logic [2:0] awprot = 3'h0;
  logic [2:0] arprot = 3'h0;
  logic [31:0] wdata = 32'h0;
  logic [3:0] wstrb = 4'hF;
  logic awvalid = 1'b0;
  logic wvalid = 1'b0;
  logic bready = 1'b0;
  logic arvalid = 1'b0;
  logic rready = 1'b0;
  logic awready, wready, bvalid, arready, rvalid, rxd, txd, irq, wakeAddressMark;
  logic [1:0] bresp, rresp, resp;
  logic [31:0] rdata, rdVal;
  logic [3:0] strb = 4'hF;
  logic [8:0] capBits;
  logic capStop, ok;
  int failCount = 0;
  int samplesChecked = 0;
  rx_row_t rows [12] = '{
    '{8'h00, 4'h0, 9'h05A, 8, 1'b1, 1'b0, 4'h0, 8'h5A},
    '{8'h04, 4'h0, 9'h001, 8, 1'b1, 1'b0, 4'h1, 8'h01},
    '{8'h00, 4'h0, 9'h001, 8, 1'b1, 1'b0, 4'h0, 8'h01},
    '{8'h04, 4'h0, 9'h003, 8, 1'b1, 1'b0, 4'h0, 8'h03},
    '{8'h10, 4'h0, 9'h1A5, 9, 1'b1, 1'b0, 4'h0, 8'hA5},
    '{8'h10, 4'h0, 9'h0A5, 9, 1'b1, 1'b0, 4'h0, 8'hA5},
    '{8'h00, 4'h0, 9'h055, 8, 1'b0, 1'b0, 4'h2, 8'h55},
    '{8'h00, 4'h3, 9'h055, 8, 1'b0, 1'b0, 4'h2, 8'h55},
    '{8'h00, 4'h3, 9'h000, 8, 1'b0, 1'b0, 4'h8, 8'h55},
    '{8'h00, 4'h7, 9'h000, 8, 1'b0, 1'b0, 4'h0, 8'h55},
    '{8'h00, 4'h1, 9'h05A, 8, 1'b1, 1'b1, 4'h4, 8'h5A},
    '{8'h00, 4'h3, 9'h05A, 8, 1'b1, 1'b1, 4'h0, 8'h5A}};

  lin_serial_status_control #(.TICK_DIV(9'h2)) lin_serial_status_control_i (
    .ref_clk, .resetn, .awaddr, .awprot, .awvalid, .awready, .wdata, .wstrb,
    .wvalid, .wready, .bresp, .bvalid, .bready, .araddr, .arprot, .arvalid,
    .arready, .rdata, .rresp, .rvalid, .rready, .rxd, .txd, .irq, .wakeAddressMark);
  lin_node_model lin_node_model_i (.ref_clk, .txd, .rxd);

  initial
  begin
    ref_clk = 1'b0;
    forever #5 ref_clk = ~ref_clk;
  end

  task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
    samplesChecked++;
    if (got !== exp)
    begin
      $display("ERROR %s expected %0h seen %0h", name, exp, got);
      failCount++;
    end
  endtask

  task automatic conclude();
    $display("checks %0d mismatches %0d", samplesChecked, failCount);
    if (failCount == 0 && samplesChecked > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  // Both channels offered together, each dropped when its own ready is seen
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    logic aw, w, done;
    aw = 1'b0;
    w = 1'b0;
    done = 1'b0;
    awaddr <= a;
    wdata <= {24'h0, d};
    wstrb <= strb;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    // No cycle limit of its own: only the watchdog ends a hung wait
    while (!done)
    begin
      @(posedge ref_clk);
      if (aw && w && bvalid === 1'b1)
      begin
        done = 1'b1;
        resp = bresp;
        bready <= 1'b0;
      end
      if (!aw && awready === 1'b1)
      begin
        aw = 1'b1;
        awvalid <= 1'b0;
      end
      if (!w && wready === 1'b1)
      begin
        w = 1'b1;
        wvalid <= 1'b0;
      end
    end
    chk("write answer", 32'h1, 32'(done));
    @(posedge ref_clk);
  endtask

  task automatic rd(input logic [7:0] a);
    logic ar, done;
    ar = 1'b0;
    done = 1'b0;
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    while (!done)
    begin
      @(posedge ref_clk);
      if (ar && rvalid === 1'b1)
      begin
        done = 1'b1;
        rdVal = rdata;
        resp = rresp;
        rready <= 1'b0;
      end
      if (!ar && arready === 1'b1)
      begin
        ar = 1'b1;
        arvalid <= 1'b0;
      end
    end
    chk("read answer", 32'h1, 32'(done));
    @(posedge ref_clk);
  endtask

  task automatic frame(input logic [8:0] bits, input logic stopBit);
    lin_node_model_i.send_frame(bits, 8, stopBit, 1'b0);
  endtask

  initial
  begin
    #500_000;
    failCount++;
    conclude();
  end

  initial
  begin
    repeat (16) @(posedge ref_clk);
    resetn <= 1'b1;
    @(posedge ref_clk);
    foreach (rows[i])
    begin
      wr(C1, rows[i].ctrl);
      wr(LC, {4'h0, rows[i].lin});
      rd(ST);
      rd(DT);
      lin_node_model_i.send_frame(rows[i].bits, rows[i].nBits, rows[i].stopBit, rows[i].glitch);
      rd(ST);
      chk("status flags", 32'(rows[i].flags), rdVal & 32'hF);
      rd(DT);
      chk("rx data", 32'(rows[i].data), rdVal);
      rd(C1);
      chk("control", 32'(rows[i].ctrl), rdVal & 32'h7F);
      if (rows[i].nBits == 9)
        chk("rx ninth", 32'(rows[i].bits[8]), 32'(rdVal[7]));
    end
    $display("receive table done");
    for (int i = 0; i < 3; i++)
    begin
      wr(C1, (i == 0) ? 8'h50 : ((i == 1) ? 8'h10 : 8'h00));
      fork
        lin_node_model_i.capture((i < 2) ? 9 : 8, capBits, capStop);
        wr(DT, 8'hA5);
      join
      chk("tx frame", 32'({1'(i == 0), 8'hA5}), 32'(capBits));
      chk("tx stop", 32'h1, 32'(capStop));
    end
    fork
      lin_node_model_i.capture(8, capBits, capStop);
      begin
        wr(DT, 8'h3C);
        wr(C1, 8'h20);
      end
    join
    chk("tx before sleep", 32'h3C, 32'(capBits));
    wr(DT, 8'h99);
    lin_node_model_i.quiet(400, ok);
    chk("txd quiet", 32'h1, 32'(ok));
    wr(C1, 8'h00);
    fork
      lin_node_model_i.capture(8, capBits, capStop);
      wr(DT, 8'h99);
    join
    chk("tx after wake", 32'h99, 32'(capBits));
    $display("transmit and power-down done");
    wr(C1, 8'h04);
    wr(LC, 8'h0B);
    wr(IM, 8'h00);
    rd(ST);
    rd(DT);
    frame(9'h000, 1'b0);
    frame(9'h055, 1'b1);
    frame(9'h000, 1'b1);
    rd(DT);
    rd(ST);
    chk("id parity flag", 32'h1, rdVal & 32'h1);
    chk("irq disabled", 32'h0, 32'(irq));
    wr(C1, 8'h05);
    chk("irq parity", 32'h1, 32'(irq));
    wr(DT, 8'h00);
    chk("irq cleared", 32'h0, 32'(irq));
    rd(ST);
    chk("parity cleared", 32'h0, rdVal & 32'h1);
    repeat (400) @(posedge ref_clk);
    wr(C1, 8'h00);
    wr(LC, 8'h00);
    rd(ST);
    rd(DT);
    frame(9'h055, 1'b0);
    rd(DT);
    rd(ST);
    chk("framing kept", 32'h2, rdVal & 32'h2);
    wr(DT, 8'h00);
    rd(ST);
    chk("framing after write", 32'h2, rdVal & 32'h2);
    rd(DT);
    rd(ST);
    chk("framing cleared", 32'h0, rdVal & 32'h2);
    repeat (400) @(posedge ref_clk);
    $display("flag clearing done");
    wr(IM, 8'h01);
    wr(IS, 8'h0F);
    chk("irq idle", 32'h0, 32'(irq));
    frame(9'h011, 1'b1);
    chk("irq rx", 32'h1, 32'(irq));
    rd(IS);
    chk("irq status", 32'h1, rdVal & 32'h1);
    wr(IM, 8'h00);
    chk("irq masked", 32'h0, 32'(irq));
    wr(IM, 8'h01);
    chk("irq unmasked", 32'h1, 32'(irq));
    wr(IS, 8'h01);
    chk("irq w1c", 32'h0, 32'(irq));
    for (int i = 0; i < 4; i++)
    begin
      wr(C1, {4'h0, i[0], 3'h0});
      wr(LC, {7'h0, i[1]});
      chk("wake method", 32'(i[0] | i[1]), 32'(wakeAddressMark));
    end
    strb = 4'hE;
    wr(C1, 8'h04);
    strb = 4'hF;
    rd(C1);
    chk("strobe low", 32'h08, rdVal & 32'h7F);
    wr(8'h20, 8'h01);
    chk("unmapped write", 32'(lin_serial_pkg::RESP_SLVERR), 32'(resp));
    rd(8'h20);
    chk("unmapped read", 32'(lin_serial_pkg::RESP_SLVERR), 32'(resp));
    chk("unmapped data", 32'h0, rdVal);
    $display("interrupt, wake and map done");
    wr(C1, 8'h15);
    wr(LC, 8'h0F);
    resetn <= 1'b0;
    repeat (16) @(posedge ref_clk);
    chk("txd in reset", 32'h1, 32'(txd));
    resetn <= 1'b1;
    @(posedge ref_clk);
    rd(C1);
    chk("control reset", 32'(lin_serial_pkg::C1_RESET), rdVal);
    rd(LC);
    chk("lin reset", 32'(lin_serial_pkg::LC_RESET), rdVal);
    rd(IM);
    chk("mask reset", 32'(lin_serial_pkg::IRQ_RESET), rdVal);
    rd(ST);
    chk("status reset", 32'h0, rdVal);
    chk("irq reset", 32'h0, 32'(irq));
    $display("reset done");
    conclude();
  end
endmodule
